// ===== rtl/anps_pkg.sv
package anps_pkg;
  // Printed offsets are register indices; byte address is four times the index
  localparam logic [7:0]  IDX_PARTNER  = 8'h05;
  localparam logic [7:0]  IDX_EXPAND   = 8'h06;
  localparam logic [7:0]  IDX_CONFIG   = 8'h08;
  localparam logic [7:0]  IDX_IRQ_STAT = 8'h09;
  localparam logic [7:0]  IDX_IRQ_EN   = 8'h0a;
  localparam logic [7:0]  IDX_IRQ_CLR  = 8'h0b;
  // Partner ability fields
  localparam int          PA_NEXT_PAGE = 15;
  localparam int          PA_ACK       = 14;
  localparam int          PA_RFAULT    = 13;
  localparam int          PA_TECH_HI   = 12;
  localparam int          PA_TECH_LO   = 5;
  localparam int          PA_SEL_HI    = 4;
  localparam int          PA_SEL_LO    = 0;
  localparam logic [15:0] PA_RESET     = 16'h0000;
  // Expansion fields
  localparam int          EX_PD_FAULT  = 4;
  localparam int          EX_LP_NP     = 3;
  localparam int          EX_NP_ABLE   = 2;
  localparam int          EX_PAGE_RX   = 1;
  localparam int          EX_LP_AN     = 0;
  localparam logic        EX_NP_RESET  = 1'b1;
  // Own configuration fields
  localparam int          CF_AN_EN     = 0;
  localparam int          CF_LEGACY    = 1;
  localparam logic [1:0]  CF_RESET     = 2'h1;
  // Interrupt events
  localparam int          IRQ_N        = 2;
  localparam int          IRQ_PAGE     = 0;
  localparam int          IRQ_PDF      = 1;
  localparam logic [1:0]  HTRANS_NSEQ  = 2'h2;
endpackage : anps_pkg

// ===== rtl/anps_page_capture.sv
`timescale 1ns/1ps
`default_nettype none
module anps_page_capture (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // From the negotiation engine
  input  wire logic        negRestart,
  input  wire logic        pageValid,
  input  wire logic [15:0] pageWord,
  // Captured pages
  output logic      [15:0] ability_q,
  output logic      [15:0] nextPage_q,
  output logic             baseSeen_q
);
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      baseSeen_q <= 1'b0;
    end else if (negRestart) begin
      baseSeen_q <= 1'b0;
    end else if (pageValid) begin
      baseSeen_q <= 1'b1;
    end
  end

  // First page after a restart is the base page, the rest are next pages
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ability_q <= anps_pkg::PA_RESET;
    end else if (negRestart) begin
      ability_q <= anps_pkg::PA_RESET;
    end else if (pageValid && !baseSeen_q) begin
      ability_q <= pageWord;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      nextPage_q <= 16'h0000;
    end else if (pageValid && baseSeen_q && !negRestart) begin
      nextPage_q <= pageWord;
    end
  end
endmodule : anps_page_capture
`default_nettype wire

// ===== rtl/anps_irq.sv
`timescale 1ns/1ps
`default_nettype none
module anps_irq #(
  parameter int N = 2
) (
  // Clock and reset
  input  wire logic         clk,
  input  wire logic         rst_n,
  // Events and software access
  input  wire logic [N-1:0] event_i,
  input  wire logic         enWr,
  input  wire logic         clrWr,
  input  wire logic [N-1:0] wdata,
  // State
  output logic      [N-1:0] status_q,
  output logic      [N-1:0] enable_q,
  output logic              irq
);
  genvar i;
  generate
    for (i = 0; i < N; i++) begin : g_bit
      // Set wins over a clear in the same cycle
      always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
          status_q[i] <= 1'b0;
        end else if (event_i[i]) begin
          status_q[i] <= 1'b1;
        end else if (clrWr && wdata[i]) begin
          status_q[i] <= 1'b0;
        end
      end
    end
  endgenerate

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= '0;
    end else if (enWr) begin
      enable_q <= wdata;
    end
  end

  assign irq = |(status_q & enable_q);
endmodule : anps_irq
`default_nettype wire

// ===== rtl/anps_regs.sv
`timescale 1ns/1ps
`default_nettype none
module anps_regs (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // AHB-Lite slave
  input  wire logic        hsel,
  input  wire logic [31:0] haddr,
  input  wire logic [1:0]  htrans,
  input  wire logic        hwrite,
  input  wire logic [2:0]  hsize,
  input  wire logic [31:0] hwdata,
  input  wire logic        hready,
  output logic      [31:0] hrdata,
  output logic             hreadyout,
  output logic             hresp,
  // Negotiation engine
  input  wire logic        negRestart,
  input  wire logic        pageValid,
  input  wire logic [15:0] pageWord,
  input  wire logic        bothLinksUp,
  input  wire logic        linkNotHeld,
  // Status outputs
  output logic      [15:0] nextPageData,
  output logic             remoteFaultStatus,
  output logic             irq
);
  logic [15:0]            ability;
  logic [15:0]            nextPageQ;
  logic                   baseSeen;
  logic                   addrValid;
  logic                   wrPend_q;
  logic [7:0]             wrIdx_q;
  logic [7:0]             rdIdx;
  logic [31:0]            rdata_d;
  logic [31:0]            hrdata_q;
  logic [1:0]             config_q;
  logic                   pdFault_q;
  logic                   pageRx_q;
  logic                   expRead;
  logic                   pdEvent;
  logic                   npAble;
  logic [15:0]            expansion;
  logic [anps_pkg::IRQ_N-1:0] irqEvt;
  logic [anps_pkg::IRQ_N-1:0] irqStat;
  logic [anps_pkg::IRQ_N-1:0] irqEn;

  anps_page_capture u_capture (
    .clk        (clk),
    .rst_n      (rst_n),
    .negRestart (negRestart),
    .pageValid  (pageValid),
    .pageWord   (pageWord),
    .ability_q  (ability),
    .nextPage_q (nextPageQ),
    .baseSeen_q (baseSeen)
  );

  assign nextPageData = nextPageQ;

  // Bus: zero wait state, always OKAY
  assign hreadyout = 1'b1;
  assign hresp     = 1'b0;
  assign hrdata    = hrdata_q;
  assign addrValid = hsel && hready && (htrans == anps_pkg::HTRANS_NSEQ || htrans == 2'h3);
  assign rdIdx     = haddr[9:2];

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      wrIdx_q  <= 8'h00;
    end else if (hready) begin
      wrPend_q <= addrValid && hwrite;
      wrIdx_q  <= rdIdx;
    end
  end

  // Configuration: negotiation enable and legacy mode
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      config_q <= anps_pkg::CF_RESET;
    end else if (wrPend_q && wrIdx_q == anps_pkg::IDX_CONFIG) begin
      config_q <= hwdata[1:0];
    end
  end

  // Legacy mode hides local next-page ability
  assign npAble = anps_pkg::EX_NP_RESET && !config_q[anps_pkg::CF_LEGACY];

  assign remoteFaultStatus = ability[anps_pkg::PA_RFAULT] && config_q[anps_pkg::CF_AN_EN];

  // Self-clearing flags: an event in the read cycle survives to the next read
  assign expRead = addrValid && !hwrite && rdIdx == anps_pkg::IDX_EXPAND;
  assign pdEvent = bothLinksUp || linkNotHeld;

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pdFault_q <= 1'b0;
    end else if (pdEvent) begin
      pdFault_q <= 1'b1;
    end else if (expRead) begin
      pdFault_q <= 1'b0;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      pageRx_q <= 1'b0;
    end else if (pageValid) begin
      pageRx_q <= 1'b1;
    end else if (expRead) begin
      pageRx_q <= 1'b0;
    end
  end

  always_comb begin
    expansion = 16'h0000;
    expansion[anps_pkg::EX_PD_FAULT] = pdFault_q;
    expansion[anps_pkg::EX_LP_NP]    = baseSeen && ability[anps_pkg::PA_NEXT_PAGE];
    expansion[anps_pkg::EX_NP_ABLE]  = npAble;
    expansion[anps_pkg::EX_PAGE_RX]  = pageRx_q;
    expansion[anps_pkg::EX_LP_AN]    = baseSeen;
  end

  // Read mux; partner and expansion have no write path
  always_comb begin
    case (rdIdx)
      anps_pkg::IDX_PARTNER:  rdata_d = {16'h0000, ability};
      anps_pkg::IDX_EXPAND:   rdata_d = {16'h0000, expansion};
      anps_pkg::IDX_CONFIG:   rdata_d = {30'h0, config_q};
      anps_pkg::IDX_IRQ_STAT: rdata_d = {30'h0, irqStat};
      anps_pkg::IDX_IRQ_EN:   rdata_d = {30'h0, irqEn};
      default:                rdata_d = 32'h0000_0000;
    endcase
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      hrdata_q <= 32'h0000_0000;
    end else if (addrValid && !hwrite) begin
      hrdata_q <= rdata_d;
    end
  end

  assign irqEvt[anps_pkg::IRQ_PAGE] = pageValid;
  assign irqEvt[anps_pkg::IRQ_PDF]  = pdEvent;

  anps_irq #(
    .N (anps_pkg::IRQ_N)
  ) u_irq (
    .clk      (clk),
    .rst_n    (rst_n),
    .event_i  (irqEvt),
    .enWr     (wrPend_q && wrIdx_q == anps_pkg::IDX_IRQ_EN),
    .clrWr    (wrPend_q && wrIdx_q == anps_pkg::IDX_IRQ_CLR),
    .wdata    (hwdata[anps_pkg::IRQ_N-1:0]),
    .status_q (irqStat),
    .enable_q (irqEn),
    .irq      (irq)
  );

  // Checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);

  sequence base_page_s;
    pageValid && !baseSeen && !negRestart;
  endsequence

  sequence next_page_s;
    pageValid && baseSeen && !negRestart;
  endsequence

  base_capture_a: assert property (base_page_s |=> ability == $past(pageWord) && baseSeen)
    else $error("base page not captured");

  next_keeps_a: assert property (next_page_s |=> ability == $past(ability)
                                 && nextPageQ == $past(pageWord))
    else $error("next page disturbed partner ability");

  rf_status_a: assert property (remoteFaultStatus == (ability[13] && config_q[0]))
    else $error("remote fault status mismatch");

  restart_clear_a: assert property (negRestart |=> ability == 16'h0000 && !expansion[0])
    else $error("restart did not clear partner state");

  pdf_set_a: assert property (pdEvent |=> expansion[4])
    else $error("parallel fault not flagged");

  page_clear_a: assert property (expRead && !pageValid |=> !pageRx_q)
    else $error("page flag not cleared by read");

  // A second read right behind may clear it again, so only the next cycle is held
  event_kept_a: assert property (expRead && pageValid |=> pageRx_q)
    else $error("same-cycle page event lost");

  np_legacy_a: assert property (expansion[2] == !config_q[1])
    else $error("local next-page ability wrong");

  reserved_zero_a: assert property (expansion[15:5] == 11'h000)
    else $error("reserved expansion bits set");

  lp_np_a: assert property (expansion[3] == (baseSeen && ability[15]))
    else $error("partner next-page flag wrong");

  ro_write_a: assert property (wrPend_q && (wrIdx_q == 8'h05) && !pageValid && !negRestart
                               |=> $stable(ability))
    else $error("write altered partner ability");

  irq_level_a: assert property (irq == |(irqStat & irqEn))
    else $error("interrupt level wrong");

  irq_set_a: assert property (pageValid |=> irqStat[0] && pageRx_q)
    else $error("page event not recorded");
endmodule : anps_regs
`default_nettype wire

// ===== dv/anps_partner_model.sv
`timescale 1ns/1ps
`default_nettype none
module anps_partner_model (
  // Clock and reset
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Page request from the bench
  input  wire logic        go,
  input  wire logic [15:0] word,
  input  wire logic [3:0]  dly,
  // Engine side
  output logic             pageValid,
  output logic      [15:0] pageWord
);
  logic [4:0]  cnt_q;
  logic [15:0] held_q;

  // Word toggles while idle so a stale value is never mistaken for a page
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt_q     <= 5'h00;
      held_q    <= 16'h0000;
      pageValid <= 1'b0;
      pageWord  <= 16'h0000;
    end else begin
      pageValid <= 1'b0;
      pageWord  <= ~pageWord;
      if (go) begin
        cnt_q  <= {1'b0, dly} + 5'h01;
        held_q <= word;
      end else if (cnt_q != 5'h00) begin
        cnt_q <= cnt_q - 5'h01;
        if (cnt_q == 5'h01) begin
          pageValid <= 1'b1;
          pageWord  <= held_q;
        end
      end
    end
  end
endmodule : anps_partner_model
`default_nettype wire

// ===== dv/tb_autoneg_partner_status_regs.sv
`timescale 1ns/1ps
`default_nettype none
module tb_autoneg_partner_status_regs;
  logic        clk = 1'b0, rst_n = 1'b0, go = 1'b0, negRestart = 1'b0, pageValid, hready;
  logic        hwrite = 1'b0, bothLinksUp = 1'b0, linkNotHeld = 1'b0, remoteFaultStatus, irq;
  logic [1:0]  htrans = 2'h0;
  logic [3:0]  dly = 4'h0;
  logic [15:0] word = 16'h0000, pageWord, nextPageData;
  logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
  int          n_fail = 0, comparisons = 0;

  always #5 clk = ~clk;

  anps_regs uut (.clk(clk), .rst_n(rst_n), .hsel(1'b1), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hready), .hresp(), .negRestart(negRestart), .pageValid(pageValid),
    .pageWord(pageWord), .bothLinksUp(bothLinksUp), .linkNotHeld(linkNotHeld),
    .nextPageData(nextPageData), .remoteFaultStatus(remoteFaultStatus), .irq(irq));

  anps_partner_model farEnd (.clk(clk), .rst_n(rst_n), .go(go), .word(word), .dly(dly),
    .pageValid(pageValid), .pageWord(pageWord));

  task automatic end_of_test();
    $display("Mismatches %0d of %0d comparisons", n_fail, comparisons);
    if (n_fail == 0 && comparisons > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask : end_of_test

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_fail++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask : check

  // Waits on hready, never on a fixed latency
  task automatic waitReady();
    int i;
    for (i = 0; i < 50; i++) begin
      @(posedge clk);
      if (hready === 1'b1) return;
    end
    n_fail++;
    end_of_test();
  endtask : waitReady

  task automatic busXfer(input logic [31:0] a, input logic wr, input logic [31:0] d);
    haddr  <= a;
    hwrite <= wr;
    htrans <= anps_pkg::HTRANS_NSEQ;
    waitReady();
    htrans <= 2'h0;
    hwdata <= d;
    waitReady();
    rd = hrdata;
  endtask : busXfer

  task automatic readCheck(input logic [31:0] a, input logic [31:0] exp);
    busXfer(a, 1'b0, 32'h0);
    check(rd, exp);
  endtask : readCheck

  task automatic sendPage(input logic [15:0] w, input logic [3:0] d);
    int i;
    go   <= 1'b1;
    word <= w;
    dly  <= d;
    @(posedge clk);
    go <= 1'b0;
    for (i = 0; i < 30; i++) begin
      @(posedge clk);
      if (pageValid === 1'b1) begin
        // Captured word lands on this edge; callers look one edge later
        @(posedge clk);
        return;
      end
    end
    n_fail++;
    end_of_test();
  endtask : sendPage

  task automatic pulseFault(input logic both);
    bothLinksUp <= both;
    linkNotHeld <= !both;
    @(posedge clk);
    bothLinksUp <= 1'b0;
    linkNotHeld <= 1'b0;
  endtask : pulseFault

  task automatic scnReset();
    readCheck(32'h14, 32'h0);
    readCheck(32'h18, 32'h4);
    check({30'h0, irq, remoteFaultStatus}, 32'h0);
  endtask : scnReset

  task automatic scnPages();
    sendPage(16'he5e1, 4'h0);
    readCheck(32'h14, 32'he5e1);
    check({31'h0, remoteFaultStatus}, 32'h1);
    readCheck(32'h18, 32'hf);
    readCheck(32'h18, 32'hd);
    busXfer(32'h14, 1'b1, 32'h0);
    busXfer(32'h18, 1'b1, 32'hffff);
    readCheck(32'h14, 32'he5e1);
    readCheck(32'h18, 32'hd);
    sendPage(16'h1234, 4'h7);
    check({16'h0, nextPageData}, 32'h1234);
    readCheck(32'h14, 32'he5e1);
    negRestart <= 1'b1;
    @(posedge clk);
    negRestart <= 1'b0;
    sendPage(16'h0021, 4'h2);
    readCheck(32'h14, 32'h0021);
    readCheck(32'h18, 32'h7);
  endtask : scnPages

  task automatic scnFaults();
    pulseFault(1'b1);
    readCheck(32'h18, 32'h15);
    readCheck(32'h18, 32'h5);
    pulseFault(1'b0);
    readCheck(32'h18, 32'h15);
    // Event lands on the read's own address edge and must survive it
    fork
      readCheck(32'h18, 32'h5);
      pulseFault(1'b1);
    join
    readCheck(32'h18, 32'h15);
  endtask : scnFaults

  task automatic scnConfig();
    busXfer(32'h20, 1'b1, 32'h3);
    readCheck(32'h18, 32'h1);
    busXfer(32'h20, 1'b1, 32'h0);
    // Partner reports a far-end fault while negotiation is disabled
    negRestart <= 1'b1;
    @(posedge clk);
    negRestart <= 1'b0;
    sendPage(16'h2001, 4'h0);
    check({31'h0, remoteFaultStatus}, 32'h0);
    busXfer(32'h20, 1'b1, 32'h1);
    @(posedge clk);
    check({31'h0, remoteFaultStatus}, 32'h1);
    readCheck(32'h18, 32'h7);
  endtask : scnConfig

  task automatic scnIrq();
    readCheck(32'h24, 32'h3);
    check({31'h0, irq}, 32'h0);
    busXfer(32'h28, 1'b1, 32'h1);
    @(posedge clk);
    check({31'h0, irq}, 32'h1);
    busXfer(32'h2c, 1'b1, 32'h3);
    readCheck(32'h24, 32'h0);
    check({31'h0, irq}, 32'h0);
    readCheck(32'h3c, 32'h0);
  endtask : scnIrq

  initial begin
    repeat (20) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    scnReset();
    scnPages();
    scnFaults();
    scnConfig();
    scnIrq();
    end_of_test();
  end
endmodule : tb_autoneg_partner_status_regs
`default_nettype wire
